// [dual_adc_serial_readout.sv]
`timescale 1ns/10ps

// Summary of operation
// - select fall: hold, sample, start, drive outputs
// - after 13 falls, track on next rise
// - 16-clock read ends with two zeros
// - select rise: stop, outputs high impedance
// - 16 more clocks swap results across outputs
// - tristate at 32nd fall or select rise
// - first leading zero appears at select fall
// - each fall shifts; first gives second zero
// - result follows; last bit on 13th fall
// - select rise between falls 2..10 powers down
module dual_adc_serial_readout (
  input  wire logic        mclk_i,             // system clock, 10 MHz
  input  wire logic        rstn_i,             // synchronous reset, active low
  input  wire logic        select_n_i,         // conversion select pin, active low
  input  wire logic        sclk_i,             // serial clock pin
  input  wire logic [11:0] result_a_i,         // converter a result
  input  wire logic [11:0] result_b_i,         // converter b result
  output logic             serial_out_a_o,     // serial data a
  output logic             serial_out_a_oe_o,  // serial data a drive enable
  output logic             serial_out_b_o,     // serial data b
  output logic             serial_out_b_oe_o,  // serial data b drive enable
  output logic             hold_o,             // track-and-hold in hold
  output logic             partial_pd_o,       // partial power-down
  output logic             full_pd_o           // full power-down
);

  localparam int RB = adc_readout_pkg::RESULT_BITS;
  localparam int FB = adc_readout_pkg::FRAME_BITS;
  localparam int CW = adc_readout_pkg::CNT_W;
  localparam logic [CW-1:0] ONE = adc_readout_pkg::ONE_FALL;

  logic [adc_readout_pkg::SYNC_IN_W-1:0] levels;
  logic                                sel_n;
  logic                                sck;
  logic                                sel_n_prev;
  logic                                sck_prev;
  logic                                sel_fall;
  logic                                sel_rise;
  logic                                sck_fall;
  logic                                sck_rise;
  logic [CW-1:0]                       fall_cnt;
  logic [FB-1:0]                       shift_a;
  logic [FB-1:0]                       shift_b;
  logic [RB-1:0]                       cap_a;
  logic [RB-1:0]                       cap_b;
  logic                                drive;
  logic                                in_window;
  adc_readout_pkg::power_state_t       pstate;

  // ==========================================================================
  // pin conditioning and edge detection
  pin_sync #(
    .W (adc_readout_pkg::SYNC_IN_W)
  ) u_sync (
    .mclk_i  (mclk_i),
    .rstn_i  (rstn_i),
    .pin_i   ({select_n_i, sclk_i}),
    .level_o (levels)
  );

  assign sel_n = levels[1];
  assign sck   = levels[0];

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      sel_n_prev <= 1'b1;
      sck_prev   <= 1'b1;
    end else begin
      sel_n_prev <= sel_n;
      sck_prev   <= sck;
    end
  end

  assign sel_fall  = sel_n_prev & ~sel_n;
  assign sel_rise  = ~sel_n_prev & sel_n;
  assign sck_fall  = sck_prev & ~sck & ~sel_n;
  assign sck_rise  = ~sck_prev & sck & ~sel_n;
  assign in_window = (fall_cnt >= adc_readout_pkg::PD_LO_FALLS) &&
                     (fall_cnt < adc_readout_pkg::PD_HI_FALLS);

  // ==========================================================================
  // falling edge counter, saturating at the end of the dual read
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      fall_cnt <= adc_readout_pkg::FALL_ZERO;
    end else if (sel_fall) begin
      fall_cnt <= adc_readout_pkg::FALL_ZERO;
    end else if (sck_fall && fall_cnt != adc_readout_pkg::TRI_FALLS) begin
      fall_cnt <= fall_cnt + adc_readout_pkg::ONE_FALL;
    end
  end

  // ==========================================================================
  // sampling and shifting; each line carries its own result, then the other
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      shift_a <= '0;
      shift_b <= '0;
      cap_a   <= '0;
      cap_b   <= '0;
    end else if (sel_fall) begin
      cap_a   <= result_a_i;
      cap_b   <= result_b_i;
      shift_a <= {adc_readout_pkg::EDGE_PAD, result_a_i, adc_readout_pkg::MID_PAD,
                  result_b_i, adc_readout_pkg::EDGE_PAD};
      shift_b <= {adc_readout_pkg::EDGE_PAD, result_b_i, adc_readout_pkg::MID_PAD,
                  result_a_i, adc_readout_pkg::EDGE_PAD};
    end else if (sck_fall) begin
      shift_a <= {shift_a[FB-2:0], 1'b0};
      shift_b <= {shift_b[FB-2:0], 1'b0};
    end
  end

  assign serial_out_a_o = shift_a[FB-1];
  assign serial_out_b_o = shift_b[FB-1];

  // ==========================================================================
  // output drive
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      drive <= 1'b0;
    end else if (sel_fall) begin
      drive <= 1'b1;
    end else if (sel_rise) begin
      drive <= 1'b0;
    end else if (sck_fall && fall_cnt == adc_readout_pkg::LAST_FALL) begin
      drive <= 1'b0;
    end
  end

  assign serial_out_a_oe_o = drive;
  assign serial_out_b_oe_o = drive;

  // ==========================================================================
  // track-and-hold
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      hold_o <= 1'b0;
    end else if (sel_fall) begin
      hold_o <= 1'b1;
    end else if (sel_rise) begin
      hold_o <= 1'b0;
    end else if (sck_rise && fall_cnt >= adc_readout_pkg::TRACK_FALLS) begin
      hold_o <= 1'b0;
    end
  end

  // ==========================================================================
  // power-down sequencing
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      pstate <= adc_readout_pkg::PWR_NORMAL;
    end else if (sel_rise && in_window) begin
      if (pstate == adc_readout_pkg::PWR_NORMAL) begin
        pstate <= adc_readout_pkg::PWR_PARTIAL;
      end else begin
        pstate <= adc_readout_pkg::PWR_FULL;
      end
    end else if (sck_fall && fall_cnt == adc_readout_pkg::PD_HI_FALLS - ONE) begin
      pstate <= adc_readout_pkg::PWR_NORMAL;
    end
  end

  assign partial_pd_o = (pstate == adc_readout_pkg::PWR_PARTIAL);
  assign full_pd_o    = (pstate == adc_readout_pkg::PWR_FULL);

  // ==========================================================================
  // checks
  property p_start;
    @(posedge mclk_i) disable iff (!rstn_i)
      sel_fall |=> serial_out_a_oe_o && serial_out_b_oe_o && hold_o;
  endproperty
  a_start: assert property (p_start) else $error("select fall did not start");

  property p_lead_zero;
    @(posedge mclk_i) disable iff (!rstn_i)
      sel_fall |=> !serial_out_a_o && !serial_out_b_o;
  endproperty
  a_lead_zero: assert property (p_lead_zero) else $error("no leading zero");

  property p_second_zero;
    @(posedge mclk_i) disable iff (!rstn_i)
      sck_fall && !sel_fall && fall_cnt == adc_readout_pkg::FALL_ZERO
      |=> !serial_out_a_o && !serial_out_b_o;
  endproperty
  a_second_zero: assert property (p_second_zero) else $error("no second zero");

  property p_msb;
    @(posedge mclk_i) disable iff (!rstn_i)
      sck_fall && !sel_fall && fall_cnt == adc_readout_pkg::FALL_MSB
      |=> serial_out_a_o == cap_a[RB-1] && serial_out_b_o == cap_b[RB-1];
  endproperty
  a_msb: assert property (p_msb) else $error("msb not first");

  property p_lsb;
    @(posedge mclk_i) disable iff (!rstn_i)
      sck_fall && !sel_fall && fall_cnt == adc_readout_pkg::FALL_LSB
      |=> serial_out_a_o == cap_a[0] && serial_out_b_o == cap_b[0];
  endproperty
  a_lsb: assert property (p_lsb) else $error("lsb not on 13th fall");

  property p_trail;
    @(posedge mclk_i) disable iff (!rstn_i)
      sck_fall && !sel_fall && fall_cnt == adc_readout_pkg::TRACK_FALLS
      |=> !serial_out_a_o && !serial_out_b_o;
  endproperty
  a_trail: assert property (p_trail) else $error("no trailing zero");

  property p_track;
    @(posedge mclk_i) disable iff (!rstn_i)
      sck_rise && !sel_fall && !sel_rise && fall_cnt >= adc_readout_pkg::TRACK_FALLS
      |=> !hold_o;
  endproperty
  a_track: assert property (p_track) else $error("no return to track");

  property p_swap;
    @(posedge mclk_i) disable iff (!rstn_i)
      sck_fall && !sel_fall && fall_cnt == adc_readout_pkg::SWAP_FALL
      |=> serial_out_a_o == cap_b[RB-1] && serial_out_b_o == cap_a[RB-1];
  endproperty
  a_swap: assert property (p_swap) else $error("results not swapped");

  property p_stop;
    @(posedge mclk_i) disable iff (!rstn_i)
      sel_rise |=> !serial_out_a_oe_o && !serial_out_b_oe_o && !hold_o;
  endproperty
  a_stop: assert property (p_stop) else $error("select rise did not stop");

  property p_tri32;
    @(posedge mclk_i) disable iff (!rstn_i)
      sck_fall && !sel_fall && fall_cnt == adc_readout_pkg::LAST_FALL
      |=> !serial_out_a_oe_o ##1 !serial_out_a_oe_o;
  endproperty
  a_tri32: assert property (p_tri32) else $error("no tristate at 32nd fall");

  property p_pd;
    @(posedge mclk_i) disable iff (!rstn_i)
      sel_rise && in_window && pstate == adc_readout_pkg::PWR_NORMAL |=> partial_pd_o;
  endproperty
  a_pd: assert property (p_pd) else $error("no partial power-down");

endmodule

// [adc_readout_pkg.sv]
package adc_readout_pkg;

  // ==========================================================================
  // frame layout
  localparam int          RESULT_BITS = 12;
  localparam int          FRAME_BITS  = 32;
  localparam int          CNT_W       = 6;
  localparam logic [1:0]  EDGE_PAD    = 2'h0;
  localparam logic [3:0]  MID_PAD     = 4'h0;

  // ==========================================================================
  // serial clock falling edge counts
  localparam logic [CNT_W-1:0] FALL_ZERO   = 6'h00;
  localparam logic [CNT_W-1:0] FALL_MSB    = 6'h01;
  localparam logic [CNT_W-1:0] FALL_LSB    = 6'h0c;
  localparam logic [CNT_W-1:0] TRACK_FALLS = 6'h0d;
  localparam logic [CNT_W-1:0] SWAP_FALL   = 6'h11;
  localparam logic [CNT_W-1:0] LAST_FALL   = 6'h1f;
  localparam logic [CNT_W-1:0] TRI_FALLS   = 6'h20;
  localparam logic [CNT_W-1:0] PD_LO_FALLS = 6'h02;
  localparam logic [CNT_W-1:0] PD_HI_FALLS = 6'h0a;
  localparam logic [CNT_W-1:0] ONE_FALL    = 6'h01;

  // ==========================================================================
  // clocking and input conditioning
  localparam int MCLK_PERIOD_NS = 100;
  localparam int SYNC_IN_W      = 2;

  typedef enum logic [1:0] {
    PWR_NORMAL,
    PWR_PARTIAL,
    PWR_FULL
  } power_state_t;

endpackage

// [pin_sync.sv]
`timescale 1ns/10ps

module pin_sync #(
  parameter int W = 2
) (
  input  wire logic         mclk_i,   // system clock
  input  wire logic         rstn_i,   // synchronous reset, active low
  input  wire logic [W-1:0] pin_i,    // asynchronous pin levels
  output logic      [W-1:0] level_o   // filtered level
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // ==========================================================================
  // three stages; the level moves only when the last two stages agree
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
          s1[g]      <= 1'b1;
          s2[g]      <= 1'b1;
          s3[g]      <= 1'b1;
          level_o[g] <= 1'b1;
        end else begin
          s1[g] <= pin_i[g];
          s2[g] <= s1[g];
          s3[g] <= s2[g];
          if (s2[g] == s3[g]) begin
            level_o[g] <= s3[g];
          end
        end
      end
    end
  endgenerate

endmodule

// [host_port_model.sv]
`timescale 1ns/10ps

// ==========================================================================
// serial port master: the clock idles high outside frames
module host_port_model (
  input  wire logic mclk_i,      // system clock
  output logic      select_n_o,  // select, active low
  output logic      sclk_o,      // serial clock
  input  wire logic line_a_i,    // resolved data line a
  input  wire logic line_b_i     // resolved data line b
);
  logic cap_a [0:32];
  logic cap_b [0:32];

  initial begin
    select_n_o = 1'b1;
    sclk_o     = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  // bits are taken just before each falling edge, the last one after the tail
  task automatic frame(input int falls);
    select_n_o = 1'b0;
    tick(8);
    for (int k = 0; k < falls; k++) begin
      cap_a[k] = line_a_i;
      cap_b[k] = line_b_i;
      sclk_o   = 1'b0;
      tick(4);
      sclk_o   = 1'b1;
      tick(4);
    end
    tick(8);
    cap_a[falls] = line_a_i;
    cap_b[falls] = line_b_i;
  endtask

  task automatic finish_frame();
    select_n_o = 1'b1;
    tick(12);
  endtask
endmodule

// [tb_top.sv]
`timescale 1ns/10ps

module tb_top;
  logic        mclk;
  logic        rstn;
  logic        select_n;
  logic        sclk;
  logic [11:0] result_a;
  logic [11:0] result_b;
  logic        serial_out_a_o;
  logic        serial_out_a_oe_o;
  logic        serial_out_b_o;
  logic        serial_out_b_oe_o;
  logic        hold_o;
  logic        partial_pd_o;
  logic        full_pd_o;
  wire         line_a;
  wire         line_b;
  int          fails;
  int          num_checks;

  assign line_a = serial_out_a_oe_o ? serial_out_a_o : 1'bz;
  assign line_b = serial_out_b_oe_o ? serial_out_b_o : 1'bz;

  dual_adc_serial_readout u_dual_adc_serial_readout (
    .mclk_i            (mclk),
    .rstn_i            (rstn),
    .select_n_i        (select_n),
    .sclk_i            (sclk),
    .result_a_i        (result_a),
    .result_b_i        (result_b),
    .serial_out_a_o    (serial_out_a_o),
    .serial_out_a_oe_o (serial_out_a_oe_o),
    .serial_out_b_o    (serial_out_b_o),
    .serial_out_b_oe_o (serial_out_b_oe_o),
    .hold_o            (hold_o),
    .partial_pd_o      (partial_pd_o),
    .full_pd_o         (full_pd_o)
  );

  host_port_model u_host_port_model (
    .mclk_i     (mclk),
    .select_n_o (select_n),
    .sclk_o     (sclk),
    .line_a_i   (line_a),
    .line_b_i   (line_b)
  );

  initial mclk = 1'b0;
  always #50 mclk = ~mclk;

  // ==========================================================================
  // comparison and closing
  task automatic cmp_bit(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask

  task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic test_done();
    if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // captured bit k lands in bit 31-k, unused places read zero
  function automatic logic [31:0] grab(input bit line_b_sel, input int n);
    logic [31:0] w;
    w = 32'h0000_0000;
    for (int k = 0; k < n; k++)
      w[31-k] = line_b_sel ? u_host_port_model.cap_b[k] : u_host_port_model.cap_a[k];
    return w;
  endfunction

  // ==========================================================================
  // scenarios
  task automatic t_power();
    u_host_port_model.frame(1);
    u_host_port_model.finish_frame();
    cmp_bit("partial_pd", 1'b0, partial_pd_o);
    u_host_port_model.frame(5);
    cmp_bit("hold", 1'b1, hold_o);
    cmp_bit("oe b", 1'b1, serial_out_b_oe_o);
    u_host_port_model.finish_frame();
    cmp_bit("partial_pd", 1'b1, partial_pd_o);
    cmp_bit("oe a", 1'b0, serial_out_a_oe_o);
    u_host_port_model.frame(5);
    u_host_port_model.finish_frame();
    cmp_bit("full_pd", 1'b1, full_pd_o);
    u_host_port_model.frame(12);
    cmp_bit("hold", 1'b1, hold_o);
    cmp_bit("full_pd", 1'b0, full_pd_o);
    u_host_port_model.finish_frame();
    cmp_bit("partial_pd", 1'b0, partial_pd_o);
  endtask

  task automatic t_single_read();
    result_a = 12'hc35;
    result_b = 12'h5ca;
    u_host_port_model.frame(16);
    cmp_word("frame a", {2'b00, 12'hc35, 18'h0_0000}, grab(1'b0, 16));
    cmp_word("frame b", {2'b00, 12'h5ca, 18'h0_0000}, grab(1'b1, 16));
    cmp_bit("hold", 1'b0, hold_o);
    cmp_bit("oe a", 1'b1, serial_out_a_oe_o);
    u_host_port_model.finish_frame();
    cmp_bit("oe a", 1'b0, serial_out_a_oe_o);
    cmp_bit("oe b", 1'b0, serial_out_b_oe_o);
  endtask

  task automatic t_dual_read();
    result_a = 12'h3ca;
    result_b = 12'ha35;
    u_host_port_model.frame(32);
    cmp_word("dual a", {2'b00, 12'h3ca, 4'h0, 12'ha35, 2'b00}, grab(1'b0, 32));
    cmp_word("dual b", {2'b00, 12'ha35, 4'h0, 12'h3ca, 2'b00}, grab(1'b1, 32));
    cmp_bit("line a after 32", 1'bz, u_host_port_model.cap_a[32]);
    cmp_bit("oe a", 1'b0, serial_out_a_oe_o);
    cmp_bit("oe b", 1'b0, serial_out_b_oe_o);
    u_host_port_model.finish_frame();
  endtask

  initial begin
    fails      = 0;
    num_checks = 0;
    rstn       = 1'b0;
    result_a   = 12'h000;
    result_b   = 12'h000;
    u_host_port_model.tick(4);
    rstn = 1'b1;
    u_host_port_model.tick(6);
    t_power();
    t_single_read();
    t_dual_read();
    test_done();
  end

  initial begin
    #2000000;
    fails++;
    test_done();
  end
endmodule
